//--- common/ivfs_map.svh
// command codes, field positions, reset values and timing for the input voltage supervisor
`ifndef IVFS_MAP_SVH
`define IVFS_MAP_SVH

`define IVFS_CMD_CLEAR_FAULTS 8'h03
`define IVFS_CMD_OV_FAULT_THR 8'h55
`define IVFS_CMD_OV_FAULT_ACT 8'h56
`define IVFS_CMD_OV_WARN_THR 8'h57
`define IVFS_CMD_UV_WARN_THR 8'h58
`define IVFS_CMD_UV_FAULT_THR 8'h59
`define IVFS_CMD_UV_FAULT_ACT 8'h5A
`define IVFS_CMD_STATUS_WORD 8'h79
`define IVFS_CMD_STATUS_INPUT 8'h7C

`define IVFS_RST_OV_FAULT_THR 16'hD3A0
`define IVFS_RST_OV_WARN_THR 16'hD34D
`define IVFS_RST_UV_WARN_THR 16'hCA30
`define IVFS_RST_UV_FAULT_THR 16'hCA00
`define IVFS_RST_FAULT_ACT 8'h80

`define IVFS_ACT_BEH_HI 7
`define IVFS_ACT_BEH_LO 6
`define IVFS_ACT_RETRY_HI 5
`define IVFS_ACT_RETRY_LO 3
`define IVFS_ACT_DELAY_HI 2
`define IVFS_ACT_DELAY_LO 0
`define IVFS_RETRY_NONE 3'h0
`define IVFS_RETRY_FOREVER 3'h7

`define IVFS_L11_EXP_HI 15
`define IVFS_L11_EXP_LO 11
`define IVFS_L11_MAN_HI 10
`define IVFS_L11_MAN_LO 0
`define IVFS_MEAS_FRAC_BITS 8

`define IVFS_SI_OV_FAULT 7
`define IVFS_SI_OV_WARN 6
`define IVFS_SI_UV_WARN 5
`define IVFS_SI_UV_FAULT 4
`define IVFS_SW_INPUT 13
`define IVFS_SW_OFF 6
`define IVFS_SW_UV_FAULT 3
`define IVFS_SW_NONE_ABOVE 0

`define IVFS_CLK_MHZ 100
`define IVFS_OV_DLY_UNIT_US 1000
`define IVFS_UV_DLY_UNIT_US 1000
`define IVFS_OV_DLY_UNIT_CYC (`IVFS_OV_DLY_UNIT_US * `IVFS_CLK_MHZ)
`define IVFS_UV_DLY_UNIT_CYC (`IVFS_UV_DLY_UNIT_US * `IVFS_CLK_MHZ)

`endif

//--- common/ivfs_pkg.sv
// types shared by the input voltage supervisor modules
package ivfs_pkg;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] code;
      logic [15:0] wdata;
   } ivfs_cmd_t;

   typedef enum logic [2:0] {
      IVFS_IDLE = 3'b000,
      IVFS_DELAY = 3'b001,
      IVFS_OFF = 3'b010,
      IVFS_HOLD = 3'b011,
      IVFS_LATCH = 3'b100
   } ivfs_resp_st_t;

   typedef struct packed {
      ivfs_resp_st_t st;
      logic [23:0] tick;
      logic [2:0] units;
      logic [2:0] used;
      logic en;
   } ivfs_resp_state_t;

   typedef struct packed {
      logic [15:0] ov_fault_thr;
      logic [7:0] ov_fault_act;
      logic [15:0] ov_warn_thr;
      logic [15:0] uv_warn_thr;
      logic [15:0] uv_fault_thr;
      logic [7:0] uv_fault_act;
      logic [7:0] sts_input;
      logic uv_cond;
      logic [15:0] rdata;
      logic rvalid;
      logic err;
   } ivfs_state_t;

endpackage : ivfs_pkg

//--- logic/ivfs_fault_resp.sv
// fault response engine: delay, disable, retry and hold-while-present
`include "ivfs_map.svh"
module ivfs_fault_resp
   import ivfs_pkg::*;
#(
   parameter int DLY_UNIT_CYC = 100000
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic fault_i,
   input wire logic [7:0] action_i,
   input wire logic restart_i,
   output logic out_en_o,
   output logic latched_o
);

   ivfs_resp_state_t r_ff, nxt_r;
   logic [1:0] beh;
   logic [2:0] retry;
   logic [2:0] dly;
   logic wait_done;
   logic out_of_tries;

   assign beh = action_i[`IVFS_ACT_BEH_HI:`IVFS_ACT_BEH_LO];
   assign retry = action_i[`IVFS_ACT_RETRY_HI:`IVFS_ACT_RETRY_LO];
   assign dly = action_i[`IVFS_ACT_DELAY_HI:`IVFS_ACT_DELAY_LO];
   assign wait_done = (r_ff.tick == 24'h000000) && (r_ff.units == 3'h0);
   assign out_of_tries = (retry == `IVFS_RETRY_NONE) ||
                         ((retry != `IVFS_RETRY_FOREVER) && (r_ff.used >= retry));

   always_comb begin
      nxt_r = r_ff;
      // prescaled delay: units of DLY_UNIT_CYC cycles
      if (r_ff.tick != 24'h000000) begin
         nxt_r.tick = r_ff.tick - 24'h000001;
      end else if (r_ff.units != 3'h0) begin
         nxt_r.units = r_ff.units - 3'h1;
         nxt_r.tick = 24'(DLY_UNIT_CYC - 1);
      end
      unique case (r_ff.st)
         IVFS_IDLE: begin
            if (fault_i) begin
               unique case (beh)
                  2'b00: nxt_r.st = IVFS_IDLE;
                  2'b01: begin
                     nxt_r.st = IVFS_DELAY;
                     nxt_r.units = dly;
                     nxt_r.tick = 24'h000000;
                  end
                  2'b10: begin
                     nxt_r.st = out_of_tries ? IVFS_LATCH : IVFS_OFF;
                     nxt_r.units = dly;
                     nxt_r.tick = 24'h000000;
                     if (!out_of_tries && retry != `IVFS_RETRY_FOREVER) begin
                        nxt_r.used = r_ff.used + 3'h1;
                     end
                  end
                  2'b11: nxt_r.st = IVFS_HOLD;
               endcase
            end
         end
         IVFS_DELAY: begin
            if (!fault_i) begin
               nxt_r.st = IVFS_IDLE;
            end else if (wait_done) begin
               nxt_r.st = out_of_tries ? IVFS_LATCH : IVFS_OFF;
               nxt_r.units = dly;
               nxt_r.tick = 24'h000000;
               if (!out_of_tries && retry != `IVFS_RETRY_FOREVER) begin
                  nxt_r.used = r_ff.used + 3'h1;
               end
            end
         end
         IVFS_OFF: begin
            // restart after the interval, fault present or not
            if (wait_done) begin
               nxt_r.st = IVFS_IDLE;
            end
         end
         IVFS_HOLD: begin
            if (!fault_i) begin
               nxt_r.st = IVFS_IDLE;
            end
         end
         IVFS_LATCH: nxt_r.st = IVFS_LATCH;
         default: nxt_r.st = IVFS_IDLE;
      endcase
      if (restart_i) begin
         nxt_r.st = IVFS_IDLE;
         nxt_r.used = 3'h0;
      end
      nxt_r.en = (nxt_r.st == IVFS_IDLE) || (nxt_r.st == IVFS_DELAY);
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r_ff <= '{st: IVFS_IDLE, tick: 24'h000000, units: 3'h0, used: 3'h0, en: 1'b1};
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign out_en_o = r_ff.en;
   assign latched_o = (r_ff.st == IVFS_LATCH);

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_ignore_mode: assert property ((r_ff.st == IVFS_IDLE && beh == 2'b00 && !restart_i)
      |=> r_ff.st == IVFS_IDLE && out_en_o)
      else $error("ignore mode left idle");
   a_hold_off: assert property ((r_ff.st == IVFS_HOLD && fault_i && !restart_i)
      |=> !out_en_o)
      else $error("output enabled while fault held");
   a_disable_now: assert property ((r_ff.st == IVFS_IDLE && fault_i && beh == 2'b10 && !restart_i)
      |=> !out_en_o)
      else $error("immediate disable missed");
   a_latch_stays: assert property ((r_ff.st == IVFS_LATCH && !restart_i)
      |=> r_ff.st == IVFS_LATCH && !out_en_o)
      else $error("latched-off state left without restart");
   c_retry: cover property (r_ff.st == IVFS_OFF ##1 r_ff.st == IVFS_IDLE);
   c_hold: cover property (r_ff.st == IVFS_HOLD ##1 r_ff.st == IVFS_IDLE);

endmodule : ivfs_fault_resp

//--- logic/ivfs_supervisor.sv
// input voltage supervisor: thresholds, fault actions, sticky input status
// Functional notes
// - ov fault threshold resets to D3A0h, 14.5 V, range 0 to 16 V
// - all thresholds are L11 words, written and read back by word commands
// - ov warning threshold resets to D34Dh, 13.2 V, range 0 to 19 V
// - above ov warning: set input and catch-all summary bits, warn flag, alert
// - below uv warning: set input and catch-all summary bits, warn flag, alert
// - uv fault condition clears only after input rises above uv warning level
// - uv warning threshold resets to CA30h, 4.38 V, range 0 to 19 V
// - uv fault threshold resets to CA00h, 4 V, range 0 to 12 V
// - action byte: bits 7:6 behaviour, 5:3 retry, 2:0 delay count
// - both action bytes reset to 80h: disable, no retry
// - every fault sets its flag, held until the clear-faults command
// - behaviour 00: keep running, only flag the fault
// - behaviour 01: wait delay count, disable, then retry per retry field
// - behaviour 10: disable at once, then retry per retry field
// - behaviour 11: off while fault present, on again when it goes
// - retry 000: stay off until the device restarts
// - retry 001 to 110: that many restarts, spaced by the delay count
// - retry 111: restart forever without checking the fault
// - delay count sets both retry spacing and response wait, unit per fault type
// - summary bit 13 reports input events, bit 0 other faults or warnings
`include "ivfs_map.svh"
module ivfs_supervisor
   import ivfs_pkg::*;
#(
   parameter int OV_DLY_UNIT_CYC = `IVFS_OV_DLY_UNIT_CYC,
   parameter int UV_DLY_UNIT_CYC = `IVFS_UV_DLY_UNIT_CYC
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire ivfs_cmd_t cmd_i,
   input wire logic [15:0] vin_meas_i,
   input wire logic restart_i,
   output logic [15:0] rdata_o,
   output logic rvalid_o,
   output logic cmd_err_o,
   output logic [15:0] status_word_o,
   output logic alert_n_o,
   output logic out_en_o
);

   // threshold in volts scaled by 2^8, same scale as vin_meas_i
   function automatic logic signed [47:0] l11_to_fx(input logic [15:0] w);
      logic signed [4:0] ex;
      logic signed [47:0] man;
      logic signed [6:0] sh;
      ex = signed'(w[`IVFS_L11_EXP_HI:`IVFS_L11_EXP_LO]);
      man = 48'(signed'(w[`IVFS_L11_MAN_HI:`IVFS_L11_MAN_LO]));
      sh = 7'(ex) + 7'sd8;
      if (sh >= 7'sd0) begin
         l11_to_fx = man <<< sh;
      end else begin
         l11_to_fx = man >>> (-sh);
      end
   endfunction : l11_to_fx

   ivfs_state_t s_ff, nxt_s;
   logic signed [47:0] vin_fx;
   logic ov_fault_cond;
   logic ov_warn_cond;
   logic uv_warn_cond;
   logic uv_fault_set;
   logic uv_fault_release;
   logic clear_faults;
   logic ov_en;
   logic uv_en;
   logic ov_latched;
   logic uv_latched;
   logic [7:0] sts_events;
   logic [15:0] status_word;

   assign vin_fx = 48'(signed'({1'b0, vin_meas_i}));
   assign ov_fault_cond = vin_fx > l11_to_fx(s_ff.ov_fault_thr);
   assign ov_warn_cond = vin_fx > l11_to_fx(s_ff.ov_warn_thr);
   assign uv_warn_cond = vin_fx < l11_to_fx(s_ff.uv_warn_thr);
   assign uv_fault_set = vin_fx < l11_to_fx(s_ff.uv_fault_thr);
   assign uv_fault_release = vin_fx > l11_to_fx(s_ff.uv_warn_thr);
   assign clear_faults = cmd_i.valid && cmd_i.write && (cmd_i.code == `IVFS_CMD_CLEAR_FAULTS);

   always_comb begin
      sts_events = 8'h00;
      sts_events[`IVFS_SI_OV_FAULT] = ov_fault_cond;
      sts_events[`IVFS_SI_OV_WARN] = ov_warn_cond;
      sts_events[`IVFS_SI_UV_WARN] = uv_warn_cond;
      sts_events[`IVFS_SI_UV_FAULT] = s_ff.uv_cond;
   end

   always_comb begin
      status_word = 16'h0000;
      status_word[`IVFS_SW_INPUT] = |s_ff.sts_input;
      status_word[`IVFS_SW_NONE_ABOVE] = s_ff.sts_input[`IVFS_SI_OV_FAULT] |
                                         s_ff.sts_input[`IVFS_SI_OV_WARN] |
                                         s_ff.sts_input[`IVFS_SI_UV_WARN];
      status_word[`IVFS_SW_UV_FAULT] = s_ff.sts_input[`IVFS_SI_UV_FAULT];
      status_word[`IVFS_SW_OFF] = !out_en_o;
   end

   always_comb begin
      nxt_s = s_ff;
      nxt_s.rvalid = 1'b0;
      nxt_s.err = 1'b0;
      // uv fault condition with hysteresis to the warning level
      if (uv_fault_set) begin
         nxt_s.uv_cond = 1'b1;
      end else if (uv_fault_release) begin
         nxt_s.uv_cond = 1'b0;
      end
      if (cmd_i.valid) begin
         if (cmd_i.write) begin
            unique case (cmd_i.code)
               `IVFS_CMD_OV_FAULT_THR: nxt_s.ov_fault_thr = cmd_i.wdata;
               `IVFS_CMD_OV_WARN_THR: nxt_s.ov_warn_thr = cmd_i.wdata;
               `IVFS_CMD_UV_WARN_THR: nxt_s.uv_warn_thr = cmd_i.wdata;
               `IVFS_CMD_UV_FAULT_THR: nxt_s.uv_fault_thr = cmd_i.wdata;
               `IVFS_CMD_OV_FAULT_ACT: nxt_s.ov_fault_act = cmd_i.wdata[7:0];
               `IVFS_CMD_UV_FAULT_ACT: nxt_s.uv_fault_act = cmd_i.wdata[7:0];
               `IVFS_CMD_CLEAR_FAULTS: nxt_s.sts_input = 8'h00;
               default: nxt_s.err = 1'b1;
            endcase
         end else begin
            nxt_s.rvalid = 1'b1;
            unique case (cmd_i.code)
               `IVFS_CMD_OV_FAULT_THR: nxt_s.rdata = s_ff.ov_fault_thr;
               `IVFS_CMD_OV_WARN_THR: nxt_s.rdata = s_ff.ov_warn_thr;
               `IVFS_CMD_UV_WARN_THR: nxt_s.rdata = s_ff.uv_warn_thr;
               `IVFS_CMD_UV_FAULT_THR: nxt_s.rdata = s_ff.uv_fault_thr;
               `IVFS_CMD_OV_FAULT_ACT: nxt_s.rdata = {8'h00, s_ff.ov_fault_act};
               `IVFS_CMD_UV_FAULT_ACT: nxt_s.rdata = {8'h00, s_ff.uv_fault_act};
               `IVFS_CMD_STATUS_WORD: nxt_s.rdata = status_word;
               `IVFS_CMD_STATUS_INPUT: nxt_s.rdata = {8'h00, s_ff.sts_input};
               default: begin
                  nxt_s.rdata = 16'h0000;
                  nxt_s.rvalid = 1'b0;
                  nxt_s.err = 1'b1;
               end
            endcase
         end
      end
      // new events win over a clear in the same cycle
      nxt_s.sts_input = nxt_s.sts_input | sts_events;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_ff <= '{
            ov_fault_thr: `IVFS_RST_OV_FAULT_THR,
            ov_fault_act: `IVFS_RST_FAULT_ACT,
            ov_warn_thr: `IVFS_RST_OV_WARN_THR,
            uv_warn_thr: `IVFS_RST_UV_WARN_THR,
            uv_fault_thr: `IVFS_RST_UV_FAULT_THR,
            uv_fault_act: `IVFS_RST_FAULT_ACT,
            sts_input: 8'h00,
            uv_cond: 1'b0,
            rdata: 16'h0000,
            rvalid: 1'b0,
            err: 1'b0
         };
      end else begin
         s_ff <= nxt_s;
      end
   end

   ivfs_fault_resp #(
      .DLY_UNIT_CYC(OV_DLY_UNIT_CYC)
   ) u_ov_resp (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .fault_i(ov_fault_cond),
      .action_i(s_ff.ov_fault_act),
      .restart_i(restart_i),
      .out_en_o(ov_en),
      .latched_o(ov_latched)
   );

   ivfs_fault_resp #(
      .DLY_UNIT_CYC(UV_DLY_UNIT_CYC)
   ) u_uv_resp (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .fault_i(s_ff.uv_cond),
      .action_i(s_ff.uv_fault_act),
      .restart_i(restart_i),
      .out_en_o(uv_en),
      .latched_o(uv_latched)
   );

   assign out_en_o = ov_en && uv_en;
   assign rdata_o = s_ff.rdata;
   assign rvalid_o = s_ff.rvalid;
   assign cmd_err_o = s_ff.err;
   assign status_word_o = status_word;
   assign alert_n_o = !(|s_ff.sts_input);

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_ov_warn_flag: assert property (ov_warn_cond |=> s_ff.sts_input[`IVFS_SI_OV_WARN]
      && status_word_o[`IVFS_SW_INPUT] && status_word_o[`IVFS_SW_NONE_ABOVE]
      && !alert_n_o)
      else $error("ov warning not flagged");
   a_uv_warn_flag: assert property (uv_warn_cond |=> s_ff.sts_input[`IVFS_SI_UV_WARN]
      && status_word_o[`IVFS_SW_INPUT] && !alert_n_o)
      else $error("uv warning not flagged");
   a_uv_hysteresis: assert property ((s_ff.uv_cond && !uv_fault_release)
      |=> s_ff.uv_cond)
      else $error("uv fault released below warning level");
   a_flag_sticky: assert property ((s_ff.sts_input[`IVFS_SI_OV_FAULT] && !clear_faults)
      |=> s_ff.sts_input[`IVFS_SI_OV_FAULT])
      else $error("fault flag dropped without clear");
   a_clear_set_wins: assert property ((clear_faults && ov_fault_cond)
      |=> s_ff.sts_input[`IVFS_SI_OV_FAULT])
      else $error("event lost under clear");
   a_word_readback: assert property ((cmd_i.valid && cmd_i.write
      && cmd_i.code == `IVFS_CMD_OV_WARN_THR) ##1 (cmd_i.valid && !cmd_i.write
      && cmd_i.code == `IVFS_CMD_OV_WARN_THR) |=> rvalid_o
      && rdata_o == $past(cmd_i.wdata, 2))
      else $error("threshold word readback mismatch");
   a_action_store: assert property ((cmd_i.valid && cmd_i.write
      && cmd_i.code == `IVFS_CMD_UV_FAULT_ACT) |=> s_ff.uv_fault_act
      == $past(cmd_i.wdata[7:0]))
      else $error("action byte not stored");
   a_summary_bit13: assert property (status_word_o[`IVFS_SW_INPUT]
      == (|s_ff.sts_input))
      else $error("summary input bit mismatch");
   a_ov_default: assert property ($rose(rst_n_i) |-> s_ff.ov_fault_thr
      == `IVFS_RST_OV_FAULT_THR && s_ff.ov_fault_act == `IVFS_RST_FAULT_ACT)
      else $error("ov defaults wrong after reset");
   c_clear: cover property (clear_faults && s_ff.sts_input != 8'h00);
   c_uv_cycle: cover property (s_ff.uv_cond ##1 !s_ff.uv_cond);
   c_latched: cover property (ov_latched || uv_latched);

endmodule : ivfs_supervisor

//--- dv/ivfs_host_model.sv
// host model: drives the supervisor command port and collects answers
module ivfs_host_model
   import ivfs_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic [15:0] rdata_i,
   input wire logic rvalid_i,
   input wire logic cmd_err_i,
   output ivfs_cmd_t cmd_o
);
   timeunit 1ns;
   timeprecision 100ps;

   initial cmd_o = '0;

   // one-cycle strobe; fields inverted after so stale values never look valid
   task automatic issue(input logic wr, input logic [7:0] code, input logic [15:0] wd);
      @(posedge ref_clk_i);
      cmd_o <= '{valid: 1'b1, write: wr, code: code, wdata: wd};
      @(posedge ref_clk_i);
      cmd_o <= '{valid: 1'b0, write: ~wr, code: ~code, wdata: ~wd};
   endtask : issue

   // error pulse stands for the cycle right after the strobe edge
   task automatic wr(input logic [7:0] code, input logic [15:0] wd, output logic err);
      issue(1'b1, code, wd);
      #1;
      err = cmd_err_i;
   endtask : wr

   // write then read of one code on consecutive edges
   task automatic wr_rd(input logic [7:0] code, input logic [15:0] wd,
                        output logic [15:0] data, output logic ok);
      @(posedge ref_clk_i);
      cmd_o <= '{valid: 1'b1, write: 1'b1, code: code, wdata: wd};
      issue(1'b0, code, 16'h0000);
      #1;
      ok = (rvalid_i === 1'b1);
      data = rdata_i;
   endtask : wr_rd

   task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic ok,
                     output logic err);
      ok = 1'b0;
      err = 1'b0;
      data = '0;
      issue(1'b0, code, 16'h0000);
      for (int i = 0; i < 3 && !ok; i++) begin
         if (i > 0) @(posedge ref_clk_i);
         #1;
         err = err | (cmd_err_i === 1'b1);
         if (rvalid_i === 1'b1) begin
            ok = 1'b1;
            data = rdata_i;
         end
      end
   endtask : rd
endmodule : ivfs_host_model

//--- dv/ivfs_supervisor_tb.sv
// self-checking bench for the input voltage supervisor
`include "ivfs_map.svh"
module ivfs_supervisor_tb
   import ivfs_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int DLY = 4;
   localparam logic [7:0] c_clr = `IVFS_CMD_CLEAR_FAULTS;
   localparam logic [7:0] c_sti = `IVFS_CMD_STATUS_INPUT;
   localparam logic [15:0] v_nom = 16'h0C00;
   logic clk;
   logic rst_n;
   logic restart;
   logic [15:0] vin;
   ivfs_cmd_t cmd;
   logic [15:0] rdata;
   logic rvalid;
   logic cmd_err;
   logic [15:0] sw;
   logic alert_n;
   logic out_en;
   int err_total = 0;
   int check_count = 0;

   ivfs_supervisor #(.OV_DLY_UNIT_CYC(DLY), .UV_DLY_UNIT_CYC(DLY)) u_dut (
      .ref_clk_i(clk), .rst_n_i(rst_n), .cmd_i(cmd), .vin_meas_i(vin), .restart_i(restart),
      .rdata_o(rdata), .rvalid_o(rvalid), .cmd_err_o(cmd_err), .status_word_o(sw),
      .alert_n_o(alert_n), .out_en_o(out_en));
   ivfs_host_model u_host (
      .ref_clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .cmd_err_i(cmd_err), .cmd_o(cmd));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic rd(input logic [7:0] code, input logic [15:0] exp);
      logic [15:0] d;
      logic ok;
      logic e;
      u_host.rd(code, d, ok, e);
      chk({15'h0, ok}, 16'h0001);
      if (ok !== 1'b1) wrap_up();
      chk(d, exp);
   endtask : rd

   task automatic put(input logic [7:0] code, input logic [15:0] wd, input logic exp_err);
      logic e;
      u_host.wr(code, wd, e);
      chk({15'h0, e}, {15'h0, exp_err});
   endtask : put

   task automatic set_vin(input logic [15:0] v, input int n);
      @(posedge clk);
      vin <= v;
      cyc(n);
   endtask : set_vin

   // device restart pulse
   task automatic kick();
      @(posedge clk);
      restart <= 1'b1;
      @(posedge clk);
      restart <= 1'b0;
      cyc(3);
   endtask : kick

   task automatic watch(input int n, output int rises, output int lows);
      logic prev;
      prev = out_en;
      rises = 0;
      lows = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         if (out_en === 1'b0) lows++;
         if (out_en === 1'b1 && prev === 1'b0) rises++;
         prev = out_en;
      end
   endtask : watch

   task automatic t_reset();
      rd(8'h55, 16'hD3A0);
      rd(8'h57, 16'hD34D);
      rd(8'h58, 16'hCA30);
      rd(8'h59, 16'hCA00);
      rd(8'h56, 16'h0080);
      rd(8'h5A, 16'h0080);
      rd(`IVFS_CMD_STATUS_WORD, 16'h0000);
      chk({14'h0, alert_n, out_en}, 16'h0003);
      $display("done reset");
   endtask : t_reset

   task automatic t_rw();
      logic [7:0] code [6] = '{8'h55, 8'h57, 8'h58, 8'h59, 8'h56, 8'h5A};
      logic [15:0] val [6] = '{16'hD3C0, 16'hD380, 16'hCA80, 16'hC980, 16'hFF3F, 16'h5507};
      logic [15:0] dft [6] = '{16'hD3A0, 16'hD34D, 16'hCA30, 16'hCA00, 16'h0080, 16'h0080};
      logic [15:0] d;
      logic ok;
      logic e;
      for (int i = 0; i < 6; i++) put(code[i], val[i], 1'b0);
      for (int i = 0; i < 6; i++) rd(code[i], i < 4 ? val[i] : {8'h00, val[i][7:0]});
      u_host.wr_rd(8'h57, 16'hD381, d, ok);
      chk({15'h0, ok}, 16'h0001);
      chk(d, 16'hD381);
      for (int i = 0; i < 6; i++) put(code[i], dft[i], 1'b0);
      u_host.rd(8'hEE, d, ok, e);
      chk({14'h0, ok, e}, 16'h0001);
      chk(rdata, 16'h0000);
      put(`IVFS_CMD_STATUS_WORD, 16'h0000, 1'b1);
      put(c_sti, 16'h0000, 1'b1);
      rd(8'h55, 16'hD3A0);
      $display("done read write");
   endtask : t_rw

   task automatic t_warn();
      set_vin(16'h0D34, 3);
      rd(c_sti, 16'h0000);
      set_vin(16'h0D35, 3);
      rd(c_sti, 16'h0040);
      chk(sw, 16'h2001);
      chk({15'h0, alert_n}, 16'h0000);
      set_vin(v_nom, 3);
      rd(c_sti, 16'h0040);
      put(c_clr, 16'h0000, 1'b0);
      rd(c_sti, 16'h0000);
      chk({sw[15:1], alert_n}, 16'h0001);
      set_vin(16'h045F, 3);
      rd(c_sti, 16'h0020);
      chk(sw, 16'h2001);
      set_vin(v_nom, 1);
      put(c_clr, 16'h0000, 1'b0);
      // 13.25 V coded with a different exponent
      put(8'h57, 16'hF035, 1'b0);
      set_vin(16'h0D40, 3);
      rd(c_sti, 16'h0000);
      set_vin(16'h0D41, 3);
      rd(c_sti, 16'h0040);
      set_vin(v_nom, 1);
      put(8'h57, 16'hD34D, 1'b0);
      put(c_clr, 16'h0000, 1'b0);
      $display("done warnings");
   endtask : t_warn

   task automatic t_uv_fault();
      int rises;
      int lows;
      set_vin(16'h03FF, 3);
      rd(c_sti, 16'h0030);
      chk(sw, 16'h2049);
      chk({15'h0, out_en}, 16'h0000);
      set_vin(16'h0460, 2);
      put(c_clr, 16'h0000, 1'b0);
      rd(c_sti, 16'h0010);
      set_vin(16'h0461, 2);
      put(c_clr, 16'h0000, 1'b0);
      rd(c_sti, 16'h0000);
      watch(20, rises, lows);
      chk(16'(lows), 16'h0014);
      kick();
      chk({15'h0, out_en}, 16'h0001);
      $display("done undervoltage fault");
   endtask : t_uv_fault

   task automatic t_ov_resp();
      logic [7:0] act [7] = '{8'h00, 8'hC0, 8'h42, 8'h82, 8'h89, 8'h92, 8'hB9};
      int rlo [7] = '{0, 0, 0, 0, 1, 2, 3};
      int rhi [7] = '{0, 0, 0, 0, 1, 2, 40};
      int llo [7] = '{0, 36, 24, 36, 0, 0, 0};
      int lhi [7] = '{0, 40, 33, 40, 40, 40, 40};
      logic [1:0] en_after [7] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
      int rises;
      int lows;
      for (int i = 0; i < 7; i++) begin
         put(8'h56, {8'h00, act[i]}, 1'b0);
         set_vin(16'h0E81, 0);
         watch(40, rises, lows);
         chk({15'h0, rises >= rlo[i] && rises <= rhi[i]}, 16'h0001);
         chk({15'h0, lows >= llo[i] && lows <= lhi[i]}, 16'h0001);
         put(c_clr, 16'h0000, 1'b0);
         rd(c_sti, 16'h00C0);
         set_vin(v_nom, 4);
         if (en_after[i] != 2'h2) chk({15'h0, out_en}, {14'h0, en_after[i]});
         put(c_clr, 16'h0000, 1'b0);
         kick();
      end
      $display("done overvoltage responses");
   endtask : t_ov_resp

   initial begin
      rst_n = 1'b0;
      restart = 1'b0;
      vin = v_nom;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_rw();
      t_warn();
      t_uv_fault();
      t_ov_resp();
      wrap_up();
   end
endmodule : ivfs_supervisor_tb
